// [zone_induct_pkg.sv]
/*
  Shared constants, register map and carrier types for the zone induct
  extension block. Assumes a 100 MHz system clock and a classic Wishbone
  master with 32-bit data and byte-address granularity.
*/
// Behaviour
// - A receiving zone's roller runs on for the forward extension after its sensor blocks.
// - Each zone of the module, upstream and downstream, holds its own extension values.
// - In time mode an extension defaults to zero and spans 0 to 65 seconds.
// - In distance mode an extension is a 16-bit motor pulse count from 0 to 65535, default zero.
// - Software selects per zone whether the extension is measured in time or in motor pulses.
// - The reverse extension applies only with reversing accumulation on and direction reverse.
// - The reverse extension is stored apart from the forward one so the two may differ.
// - With the distance metric the programmed value counts motor pulses, not seconds.
`default_nettype none

package zone_induct_pkg;

  // Clock and time base
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TIME_UNIT_NS  = 10_000_000; // One count is 0.01 s
  localparam int unsigned TICK_CYCLES   = TIME_UNIT_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK_W        = 20;
  localparam logic [15:0] TIME_MAX      = 16'h1964;   // 65.00 s in 0.01 s units

  // Zones and register map
  localparam int unsigned NZONES     = 2;
  localparam logic [7:0]  ADR_CTRL   = 8'h00;
  localparam logic [7:0]  ADR_UP_FWD = 8'h04;
  localparam logic [7:0]  ADR_UP_REV = 8'h08;
  localparam logic [7:0]  ADR_DN_FWD = 8'h0C;
  localparam logic [7:0]  ADR_DN_REV = 8'h10;
  localparam logic [7:0]  ADR_STATUS = 8'h14;

  // Extension slots: zone * 2 + direction
  localparam logic [1:0] EXT_UP_FWD = 2'h0;
  localparam logic [1:0] EXT_UP_REV = 2'h1;
  localparam logic [1:0] EXT_DN_FWD = 2'h2;
  localparam logic [1:0] EXT_DN_REV = 2'h3;

  // Control bits; metric bit per zone starts at CTRL_METRIC
  localparam int unsigned CTRL_METRIC  = 0;
  localparam int unsigned CTRL_REV_EN  = 2;
  localparam int unsigned CTRL_DIR_REV = 3;
  localparam int unsigned CTRL_W       = 4;

  // Status fields
  localparam int unsigned STAT_MOTOR  = 0;
  localparam int unsigned STAT_EXTEND = 2;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_t;

  typedef enum logic [0:0] {
    ZS_IDLE   = 1'b0,
    ZS_EXTEND = 1'b1
  } zone_state_t;

  typedef struct packed {
    zone_state_t st;
    logic [15:0] cnt;
    logic        motor;
    logic        blk_prev;
  } zone_reg_t;

  typedef struct packed {
    logic [1:0]            sens_s1;
    logic [1:0]            sens_s2;
    logic [1:0]            pls_s1;
    logic [1:0]            pls_s2;
    logic [1:0]            pls_prev;
    logic [TICK_W-1:0]     tick_cnt;
    logic                  tick;
    logic [CTRL_W-1:0]     ctrl;
    logic [3:0][15:0]      ext;
    wb_rsp_t               rsp;
  } top_reg_t;

endpackage

`default_nettype wire

// [zone_extend.sv]
/*
  One zone's induct extension sequencer and roller drive.
  Assumes sensor input already synchronised and pulse/tick strobes
  one cycle wide on the same clock.
*/
`default_nettype none

module zone_extend (
  input  wire logic        sys_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        sensor_i,
  input  wire logic        pulse_i,
  input  wire logic        tick_i,
  input  wire logic        metric_i,
  input  wire logic [15:0] target_i,
  input  wire logic        receiving_i,
  input  wire logic        discharge_ok_i,
  output logic             motor_o,
  output logic             extending_o
);

  zone_induct_pkg::zone_reg_t q, d;
  logic        adv;
  logic [15:0] lim;
  logic        blk_rise;

  // Metric selection and time range clamp
  always_comb
  begin
    adv      = metric_i ? pulse_i : tick_i;
    lim      = (!metric_i && target_i > zone_induct_pkg::TIME_MAX)
               ? zone_induct_pkg::TIME_MAX : target_i;
    blk_rise = sensor_i && !q.blk_prev;
  end

  // Next state
  always_comb
  begin
    d          = q;
    d.blk_prev = sensor_i;
    case (q.st)
      zone_induct_pkg::ZS_IDLE:
      begin
        if (receiving_i && blk_rise && lim != 16'h0000)
        begin
          d.st  = zone_induct_pkg::ZS_EXTEND;
          d.cnt = 16'h0000;
        end
      end
      zone_induct_pkg::ZS_EXTEND:
      begin
        if (adv)
        begin
          d.cnt = q.cnt + 16'h0001;
          if (q.cnt + 16'h0001 >= lim)
            d.st = zone_induct_pkg::ZS_IDLE;
        end
      end
      default: d.st = zone_induct_pkg::ZS_IDLE;
    endcase
    // Run while filling, while extending or when discharge allowed
    d.motor = (d.st == zone_induct_pkg::ZS_EXTEND) || discharge_ok_i
              || (receiving_i && !sensor_i);
  end

  // State register
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      q <= '0;
    else
      q <= d;
  end

  assign motor_o     = q.motor;
  assign extending_o = (q.st == zone_induct_pkg::ZS_EXTEND);

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  property p_start;
    q.st == zone_induct_pkg::ZS_IDLE && receiving_i && blk_rise && lim != 16'h0000
    |=> q.st == zone_induct_pkg::ZS_EXTEND && q.cnt == 16'h0000 && q.motor;
  endproperty
  a_start: assert property (p_start) else $error("extension did not start");

  property p_stop;
    q.st == zone_induct_pkg::ZS_EXTEND && adv && (q.cnt + 16'h0001 >= lim)
    |=> q.st == zone_induct_pkg::ZS_IDLE
        && q.motor == $past(discharge_ok_i || (receiving_i && !sensor_i));
  endproperty
  a_stop: assert property (p_stop) else $error("extension did not end at count");

  property p_zero;
    q.st == zone_induct_pkg::ZS_IDLE && receiving_i && blk_rise && lim == 16'h0000
    |=> q.st == zone_induct_pkg::ZS_IDLE && q.motor == $past(discharge_ok_i);
  endproperty
  a_zero: assert property (p_zero) else $error("zero extension ran motor");

  property p_time_range;
    q.st == zone_induct_pkg::ZS_EXTEND && !metric_i |-> q.cnt < zone_induct_pkg::TIME_MAX;
  endproperty
  a_time_range: assert property (p_time_range) else $error("time count past range");

  property p_dist_hold;
    q.st == zone_induct_pkg::ZS_EXTEND && metric_i && !pulse_i |=> $stable(q.cnt);
  endproperty
  a_dist_hold: assert property (p_dist_hold) else $error("count moved without pulse");

  property p_time_hold;
    q.st == zone_induct_pkg::ZS_EXTEND && !metric_i && !tick_i |=> $stable(q.cnt);
  endproperty
  a_time_hold: assert property (p_time_hold) else $error("count moved without tick");

  property p_run;
    q.st == zone_induct_pkg::ZS_EXTEND |-> q.motor;
  endproperty
  a_run: assert property (p_run) else $error("motor off during extension");

  c_done: cover property (q.st == zone_induct_pkg::ZS_EXTEND
                          ##1 q.st == zone_induct_pkg::ZS_IDLE);
  c_zero: cover property (receiving_i && blk_rise && lim == 16'h0000);
  c_dist: cover property (q.st == zone_induct_pkg::ZS_EXTEND && metric_i && pulse_i);

endmodule

`default_nettype wire

// [zone_induct_run_extension.sv]
/*
  Induct extension logic for the upstream and downstream zones of one
  conveyor module, with a classic Wishbone register slave.
  Assumes sensors and motor pulses arrive asynchronously from pins and
  that receiving and discharge permits come from logic on sys_clk_i.
*/
// Our own choices: the Wishbone register port and the register offsets.
`default_nettype none

module zone_induct_run_extension #(
  parameter int unsigned TICK_CYCLES = zone_induct_pkg::TICK_CYCLES
) (
  input  wire logic                     sys_clk_i,
  input  wire logic                     arst_n_i,
  input  wire zone_induct_pkg::wb_req_t wb_i,
  output zone_induct_pkg::wb_rsp_t      wb_o,
  input  wire logic [1:0]               zone_sensor_i,
  input  wire logic [1:0]               motor_pulse_i,
  input  wire logic [1:0]               zone_receiving_i,
  input  wire logic [1:0]               discharge_ok_i,
  output logic [1:0]                    zone_roller_motor_o
);

  zone_induct_pkg::top_reg_t q, d;
  logic [1:0] pls_edge;
  logic [1:0] ext_active;
  logic       rev_active;
  logic       req;
  logic       hit;
  logic [1:0] idx;

  // Reverse extension only in reversing accumulation, reverse direction
  assign rev_active = q.ctrl[zone_induct_pkg::CTRL_REV_EN]
                      && q.ctrl[zone_induct_pkg::CTRL_DIR_REV];
  assign pls_edge   = q.pls_s2 & ~q.pls_prev;
  assign req        = wb_i.cyc && wb_i.stb && !q.rsp.ack;

  // Decode of the extension slots
  always_comb
  begin
    hit = 1'b1;
    idx = zone_induct_pkg::EXT_UP_FWD;
    case (wb_i.adr)
      zone_induct_pkg::ADR_UP_FWD: idx = zone_induct_pkg::EXT_UP_FWD;
      zone_induct_pkg::ADR_UP_REV: idx = zone_induct_pkg::EXT_UP_REV;
      zone_induct_pkg::ADR_DN_FWD: idx = zone_induct_pkg::EXT_DN_FWD;
      zone_induct_pkg::ADR_DN_REV: idx = zone_induct_pkg::EXT_DN_REV;
      default:                     hit = 1'b0;
    endcase
  end

  // Next state: synchronisers, time base, register slave
  always_comb
  begin
    d          = q;
    d.sens_s1  = zone_sensor_i;
    d.sens_s2  = q.sens_s1;
    d.pls_s1   = motor_pulse_i;
    d.pls_s2   = q.pls_s1;
    d.pls_prev = q.pls_s2;
    // Free-running 0.01 s tick
    if (q.tick_cnt == (zone_induct_pkg::TICK_W)'(TICK_CYCLES - 1))
    begin
      d.tick_cnt = '0;
      d.tick     = 1'b1;
    end
    else
    begin
      d.tick_cnt = q.tick_cnt + (zone_induct_pkg::TICK_W)'(1);
      d.tick     = 1'b0;
    end
    // Single-cycle ack, data out of a register
    d.rsp.ack = req;
    d.rsp.dat = '0;
    if (req && hit)
    begin
      d.rsp.dat[15:0] = q.ext[idx];
      if (wb_i.we && wb_i.sel[0])
        d.ext[idx][7:0] = wb_i.dat[7:0];
      if (wb_i.we && wb_i.sel[1])
        d.ext[idx][15:8] = wb_i.dat[15:8];
    end
    else if (req && wb_i.adr == zone_induct_pkg::ADR_CTRL)
    begin
      d.rsp.dat[zone_induct_pkg::CTRL_W-1:0] = q.ctrl;
      if (wb_i.we && wb_i.sel[0])
        d.ctrl = wb_i.dat[zone_induct_pkg::CTRL_W-1:0];
    end
    else if (req && wb_i.adr == zone_induct_pkg::ADR_STATUS)
    begin
      d.rsp.dat[zone_induct_pkg::STAT_MOTOR +: 2]  = zone_roller_motor_o;
      d.rsp.dat[zone_induct_pkg::STAT_EXTEND +: 2] = ext_active;
    end
  end

  // State register, all extensions reset to zero
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      q <= '0;
    else
      q <= d;
  end

  assign wb_o = q.rsp;

  // One sequencer per zone, each with its own slots
  for (genvar g = 0; g < zone_induct_pkg::NZONES; g++)
  begin : g_zone
    logic [15:0] target;
    assign target = rev_active ? q.ext[2*g+1] : q.ext[2*g];
    zone_extend u_zone (
      .sys_clk_i      (sys_clk_i),
      .arst_n_i       (arst_n_i),
      .sensor_i       (q.sens_s2[g]),
      .pulse_i        (pls_edge[g]),
      .tick_i         (q.tick),
      .metric_i       (q.ctrl[zone_induct_pkg::CTRL_METRIC+g]),
      .target_i       (target),
      .receiving_i    (zone_receiving_i[g]),
      .discharge_ok_i (discharge_ok_i[g]),
      .motor_o        (zone_roller_motor_o[g]),
      .extending_o    (ext_active[g])
    );
  end

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  property p_ack;
    wb_i.cyc && wb_i.stb && !wb_o.ack |=> wb_o.ack ##1 !wb_o.ack;
  endproperty
  a_ack: assert property (p_ack) else $error("bus ack not single cycle");

  property p_rev_apart;
    req && wb_i.we && wb_i.adr == zone_induct_pkg::ADR_UP_REV
    |=> $stable(q.ext[zone_induct_pkg::EXT_UP_FWD])
        && $stable(q.ext[zone_induct_pkg::EXT_DN_REV]);
  endproperty
  a_rev_apart: assert property (p_rev_apart) else $error("reverse write disturbed other");

  property p_zone_apart;
    req && wb_i.we && wb_i.adr == zone_induct_pkg::ADR_DN_FWD
    |=> $stable(q.ext[zone_induct_pkg::EXT_UP_FWD]);
  endproperty
  a_zone_apart: assert property (p_zone_apart) else $error("zone values not separate");

  property p_fwd_sel;
    !rev_active |-> g_zone[0].target == q.ext[zone_induct_pkg::EXT_UP_FWD]
                    && g_zone[1].target == q.ext[zone_induct_pkg::EXT_DN_FWD];
  endproperty
  a_fwd_sel: assert property (p_fwd_sel) else $error("reverse used while forward");

  property p_rev_sel;
    rev_active |-> g_zone[0].target == q.ext[zone_induct_pkg::EXT_UP_REV]
                   && g_zone[1].target == q.ext[zone_induct_pkg::EXT_DN_REV];
  endproperty
  a_rev_sel: assert property (p_rev_sel) else $error("forward used while reverse");

  // Stored values follow full-width writes one edge later
  property p_rev_store;
    req && wb_i.we && wb_i.sel[1:0] == 2'h3 && wb_i.adr == zone_induct_pkg::ADR_UP_REV
    |=> q.ext[zone_induct_pkg::EXT_UP_REV] == $past(wb_i.dat[15:0]);
  endproperty
  a_rev_store: assert property (p_rev_store) else $error("reverse value not stored");

  property p_dn_store;
    req && wb_i.we && wb_i.sel[1:0] == 2'h3 && wb_i.adr == zone_induct_pkg::ADR_DN_FWD
    |=> q.ext[zone_induct_pkg::EXT_DN_FWD] == $past(wb_i.dat[15:0]);
  endproperty
  a_dn_store: assert property (p_dn_store) else $error("zone value not stored");

  property p_ctrl_store;
    req && wb_i.we && wb_i.sel[0] && wb_i.adr == zone_induct_pkg::ADR_CTRL
    |=> q.ctrl == $past(wb_i.dat[zone_induct_pkg::CTRL_W-1:0]);
  endproperty
  a_ctrl_store: assert property (p_ctrl_store) else $error("metric select not stored");

  // Read data stand only with ack; upper half always zero
  property p_dat_idle;
    !wb_o.ack |-> wb_o.dat == 32'h00000000;
  endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");

  property p_dat_width;
    wb_o.dat[31:16] == 16'h0000;
  endproperty
  a_dat_width: assert property (p_dat_width) else $error("read data above bit 15");

  property p_unmapped;
    req && !hit && wb_i.adr != zone_induct_pkg::ADR_CTRL
    && wb_i.adr != zone_induct_pkg::ADR_STATUS
    |=> wb_o.ack && wb_o.dat == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_stat_motor;
    req && !wb_i.we && wb_i.adr == zone_induct_pkg::ADR_STATUS
    |=> wb_o.dat[zone_induct_pkg::STAT_MOTOR +: 2] == $past(zone_roller_motor_o);
  endproperty
  a_stat_motor: assert property (p_stat_motor) else $error("status motor bits wrong");

  // Time base: one-cycle tick, counter never past its period
  property p_tick_pulse;
    q.tick |=> !q.tick;
  endproperty
  a_tick_pulse: assert property (p_tick_pulse) else $error("tick wider than a cycle");

  property p_tick_range;
    q.tick_cnt <= (zone_induct_pkg::TICK_W)'(TICK_CYCLES - 1);
  endproperty
  a_tick_range: assert property (p_tick_range) else $error("tick counter past period");

  // Pin synchronisers: two stages, pulse edge only from a pin rise
  property p_sens_sync;
    q.sens_s2 == $past(zone_sensor_i, 2);
  endproperty
  a_sens_sync: assert property (p_sens_sync) else $error("sensor sync depth wrong");

  property p_pulse_edge;
    pls_edge != 2'h0
    |-> (pls_edge & ~($past(motor_pulse_i, 2) & ~$past(motor_pulse_i, 3))) == 2'h0;
  endproperty
  a_pulse_edge: assert property (p_pulse_edge) else $error("pulse edge not from pin");

  c_rev: cover property (rev_active && ext_active[0]);
  c_write: cover property (req && wb_i.we && hit);

endmodule

`default_nettype wire

// [zone_roller_model.sv]
/*
  Roller and encoder model for both zones: pulses only while driven.
  Assumes run commands registered on sys_clk_i.
*/
`default_nettype none

module zone_roller_model (
  input  wire logic       sys_clk_i,
  input  wire logic [1:0] run_i,
  input  wire logic [3:0] half_i,
  input  wire logic       clr_i,
  output var  logic [1:0] pulse_o,
  output var  int         cnt_o [2]
);
  logic [3:0] ph_q [2];

  initial pulse_o = 2'h0;

  // Encoder toggles every half_i cycles while the roller turns
  always @(posedge sys_clk_i)
  begin
    for (int z = 0; z < 2; z++)
    begin
      if (!run_i[z])
        ph_q[z] <= 4'h0;
      else if (ph_q[z] == half_i - 4'h1)
      begin
        ph_q[z] <= 4'h0;
        pulse_o[z] <= !pulse_o[z];
        cnt_o[z] <= cnt_o[z] + int'(!pulse_o[z]);
      end
      else
        ph_q[z] <= ph_q[z] + 4'h1;
      if (clr_i)
        cnt_o[z] <= 0;
    end
  end
endmodule

`default_nettype wire

// [tb_top.sv]
/*
  Testbench for the zone induct block: bus tasks, roller model,
  queued read checks. Assumes package and design compiled first.
*/
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TK = 10;
  logic                     sys_clk_i = 1'b0;
  logic                     arst_n_i  = 1'b0;
  zone_induct_pkg::wb_req_t wb_i      = '0;
  zone_induct_pkg::wb_rsp_t wb_o;
  logic [1:0]               sens      = 2'h0;
  logic [1:0]               rcv       = 2'h0;
  logic [1:0]               dok       = 2'h0;
  logic [1:0]               mot;
  logic [1:0]               pls;
  logic [3:0]               half      = 4'h3;
  logic                     clr       = 1'b0;
  int                       cnt [2];
  int                       err_total = 0;
  int                       samples_checked = 0;
  logic [31:0]              expq [$];
  logic [15:0]              v [4];

  zone_induct_run_extension #(.TICK_CYCLES(TK)) DUT (
    .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .wb_i(wb_i), .wb_o(wb_o),
    .zone_sensor_i(sens), .motor_pulse_i(pls), .zone_receiving_i(rcv),
    .discharge_ok_i(dok), .zone_roller_motor_o(mot));

  zone_roller_model roller (.sys_clk_i(sys_clk_i), .run_i(mot), .half_i(half),
    .clr_i(clr), .pulse_o(pls), .cnt_o(cnt));

  // Clock
  always #5 sys_clk_i = ~sys_clk_i;

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // One classic cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge sys_clk_i);
    wb_i <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hF, dat: d};
    @(posedge sys_clk_i);
    while (wb_o.ack !== 1'b1 && i < 50)
    begin
      @(posedge sys_clk_i);
      i++;
    end
    if (wb_o.ack !== 1'b1)
      err_total++;
    wb_i <= '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  // Block one zone while receiving; time the run and count pulses
  task automatic ext(input int z, input int lo, input int hi, input int pe);
    int n;
    n = 3;
    @(posedge sys_clk_i);
    clr <= 1'b1;
    rcv[z] <= 1'b1;
    sens[z] <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    clr <= 1'b0;
    if (pe >= 0)
    begin
      rd(zone_induct_pkg::ADR_STATUS, 32'h5 << z);
      n = 6;
    end
    while (mot[z] === 1'b1 && n < 2000)
    begin
      @(posedge sys_clk_i);
      n++;
    end
    chk("run length in range", 32'h1, 32'(n >= lo && n <= hi));
    if (pe >= 0)
      chk("pulse count", 32'(pe), 32'(cnt[z]));
    sens[z] <= 1'b0;
    rcv[z] <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
  endtask

  // Read monitor: oldest note against each read ack
  always @(posedge sys_clk_i)
    if (wb_o.ack === 1'b1 && wb_i.we === 1'b0)
      if (expq.size() == 0)
        chk("unexpected ack", 32'h0, 32'hFFFFFFFF);
      else
        chk("read data", expq.pop_front(), wb_o.dat);

  // Main sequence
  initial
  begin
    int k;
    int l;
    void'($urandom(32'h6e2d3546));
    repeat (5) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    for (k = 1; k < 6; k++) rd(8'(k * 4), 32'h0);
    for (k = 0; k < 4; k++) v[k] = 16'($urandom);
    for (k = 0; k < 4; k++) bus(1'b1, 8'(k * 4 + 4), {16'hFFFF, v[k]});
    for (k = 0; k < 4; k++) rd(8'(k * 4 + 4), {16'h0, v[k]});
    rd(8'h18, 32'h0);
    bus(1'b1, 8'h00, 32'h3);
    rd(8'h00, 32'h3);
    l = $urandom_range(9, 2);
    bus(1'b1, 8'h04, 32'(l));
    ext(0, 0, 1999, l);
    half <= 4'h5;
    bus(1'b1, 8'h0C, 32'(l + 3));
    bus(1'b1, 8'h04, 32'h2);
    ext(1, 0, 1999, l + 3);
    half <= 4'h3;
    bus(1'b1, 8'h08, 32'h5);
    bus(1'b1, 8'h00, 32'h7);
    ext(0, 0, 1999, 2);
    bus(1'b1, 8'h00, 32'hF);
    ext(0, 0, 1999, 5);
    bus(1'b1, 8'h08, 32'h2);
    ext(0, 0, 1999, 2);
    bus(1'b1, 8'h08, 32'h0);
    ext(0, 0, 5, -1);
    bus(1'b1, 8'h00, 32'h0);
    bus(1'b1, 8'h04, 32'h4);
    ext(0, 30, 46, -1);
    dok <= 2'h2;
    rd(zone_induct_pkg::ADR_STATUS, 32'h2);
    dok <= 2'h0;
    print_verdict();
  end
endmodule

`default_nettype wire
